// ===== rtl/peripheral_module_disable.sv
/*
 * peripheral module disable: software-controlled clock gating, reset hold
 * and register-access blocking for five analog peripherals plus the
 * system-clock feed to the peripheral clock network.
 * assumes one system clock, an axi4-lite master, and a static nonvolatile
 * configuration level for the zero-cross detector (sampled through two flops).
 */
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps

// Function
// [RQ1] any reset clears every disable bit
// [RQ2] gate bit stops peripheral system clock feed
// [RQ3] only system-clock consumers lose their clock
// [RQ4] control register 2 bits six,five,two,one,zero
// [RQ5] zero-cross disable qualified by configuration bit
// [RQ6] disabled module: clock off, reset, regs blocked
// [RQ7] re-enabled module restarts from power-on state
// [RQ8] software waits one cycle after re-enable
// [RQ9] unimplemented bits ignore writes, read zero
module peripheral_module_disable (
    // clock and reset
    input wire logic clock_in,
    input wire logic arst_n_in,
    // axi4-lite write address
    input wire logic awvalid_in,
    input wire logic [7:0] awaddr_in,
    output logic awready_out,
    // axi4-lite write data
    input wire logic wvalid_in,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    output logic wready_out,
    // axi4-lite write response
    output logic bvalid_out,
    output logic [1:0] bresp_out,
    input wire logic bready_in,
    // axi4-lite read
    input wire logic arvalid_in,
    input wire logic [7:0] araddr_in,
    output logic arready_out,
    output logic rvalid_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    input wire logic rready_in,
    // nonvolatile configuration and per-peripheral system clock use
    input wire logic zero_cross_config_in,
    input wire logic [pmd_pkg::NUM_MODULES-1:0] uses_sys_clock_in,
    // peripheral controls
    output logic peripheral_sys_clock_en_out,
    output logic [pmd_pkg::NUM_MODULES-1:0] module_clock_en_out,
    output logic [pmd_pkg::NUM_MODULES-1:0] module_reset_out,
    output logic [pmd_pkg::NUM_MODULES-1:0] module_access_en_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_HALF = 3'b010,
        WR_RESP = 3'b100
    } write_state_e;

    write_state_e wr_state;
    pmd_pkg::write_req_s wr_req;
    logic aw_held;
    logic w_held;
    logic aw_take;
    logic w_take;
    logic [7:0] module_disable_ctrl_0;
    logic [7:0] module_disable_ctrl_2;
    logic zero_cross_meta;
    logic zero_cross_config;
    pmd_pkg::module_vec_s off_vec;
    logic [pmd_pkg::NUM_MODULES-1:0] off_bits;
    logic wr_fire;
    logic [7:0] next_ctrl_0;
    logic [7:0] next_ctrl_2;
    logic [1:0] next_bresp;

    // ------------------------------------------------------------
    // configuration level synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            zero_cross_meta <= 1'b0;
            zero_cross_config <= 1'b0;
        end else begin
            zero_cross_meta <= zero_cross_config_in;
            zero_cross_config <= zero_cross_meta;
        end
    end

    // ------------------------------------------------------------
    // write channel: address and data taken in either order
    // ------------------------------------------------------------
    // a half counts only once its ready was up; valid alone must not start a response
    assign aw_take = awvalid_in && awready_out;
    assign w_take = wvalid_in && wready_out;
    assign wr_fire = (wr_state != WR_RESP) && (aw_held || aw_take) && (w_held || w_take);

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_state <= WR_IDLE;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_req <= '0;
        end else begin
            case (wr_state)
                WR_IDLE, WR_HALF: begin
                    if (aw_take) begin
                        wr_req.addr <= awaddr_in;
                    end
                    if (w_take) begin
                        wr_req.data <= wdata_in;
                        wr_req.strb <= wstrb_in;
                    end
                    if (wr_fire) begin
                        aw_held <= 1'b0;
                        w_held <= 1'b0;
                        wr_state <= WR_RESP;
                    end else begin
                        aw_held <= aw_held || aw_take;
                        w_held <= w_held || w_take;
                        wr_state <= (aw_held || aw_take || w_held || w_take) ? WR_HALF : WR_IDLE;
                    end
                end
                WR_RESP: begin
                    if (bready_in && bvalid_out) begin
                        wr_state <= WR_IDLE;
                    end
                end
                default: begin
                    wr_state <= WR_IDLE;
                end
            endcase
        end
    end

    // ready only while the matching half is not yet captured
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            awready_out <= 1'b0;
            wready_out <= 1'b0;
        end else begin
            awready_out <= !wr_fire && (wr_state != WR_RESP) && !(aw_held || aw_take);
            wready_out <= !wr_fire && (wr_state != WR_RESP) && !(w_held || w_take);
        end
    end

    // ------------------------------------------------------------
    // control registers and write decode
    // ------------------------------------------------------------
    // the bus stage latches halves only on handshake; commit uses the latched copy of a held half, else the live bus input
    logic commit;
    logic [7:0] commit_addr;
    logic [7:0] commit_data;
    logic commit_lane;

    always_comb begin
        commit = (wr_state != WR_RESP) && (aw_held || (awvalid_in && awready_out))
            && (w_held || (wvalid_in && wready_out));
        commit_addr = aw_held ? wr_req.addr : awaddr_in;
        commit_data = w_held ? wr_req.data[7:0] : wdata_in[7:0];
        commit_lane = w_held ? wr_req.strb[0] : wstrb_in[0];
        next_ctrl_0 = module_disable_ctrl_0;
        next_ctrl_2 = module_disable_ctrl_2;
        next_bresp = pmd_pkg::RESP_OKAY;
        if (commit) begin
            case (commit_addr)
                pmd_pkg::MODULE_DISABLE_CTRL_0_OFFSET: begin
                    if (commit_lane) begin
                        next_ctrl_0 = commit_data & pmd_pkg::CTRL_0_MASK; // RQ9
                    end
                end
                pmd_pkg::MODULE_DISABLE_CTRL_2_OFFSET: begin
                    if (commit_lane) begin
                        next_ctrl_2 = commit_data & pmd_pkg::CTRL_2_MASK; // RQ4 RQ9
                    end
                end
                pmd_pkg::MODULE_STATUS_OFFSET: begin
                    next_bresp = pmd_pkg::RESP_OKAY;
                end
                default: begin
                    next_bresp = pmd_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            module_disable_ctrl_0 <= pmd_pkg::CTRL_RESET; // RQ1
            module_disable_ctrl_2 <= pmd_pkg::CTRL_RESET; // RQ1
        end else begin
            module_disable_ctrl_0 <= next_ctrl_0;
            module_disable_ctrl_2 <= next_ctrl_2;
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bvalid_out <= 1'b0;
            bresp_out <= pmd_pkg::RESP_OKAY;
        end else if (commit) begin
            bvalid_out <= 1'b1;
            bresp_out <= next_bresp;
        end else if (bready_in) begin
            bvalid_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read channel: one cycle after the address is taken
    // ------------------------------------------------------------
    logic [31:0] read_word;
    logic read_ok;

    always_comb begin
        read_word = 32'h0000_0000;
        read_ok = 1'b1;
        case (araddr_in)
            pmd_pkg::MODULE_DISABLE_CTRL_0_OFFSET: read_word = {24'h00_0000, module_disable_ctrl_0};
            pmd_pkg::MODULE_DISABLE_CTRL_2_OFFSET: read_word = {24'h00_0000, module_disable_ctrl_2};
            pmd_pkg::MODULE_STATUS_OFFSET: read_word = {27'h000_0000, off_bits};
            default: read_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            arready_out <= 1'b0;
            rvalid_out <= 1'b0;
            rdata_out <= 32'h0000_0000;
            rresp_out <= pmd_pkg::RESP_OKAY;
        end else if (arvalid_in && arready_out) begin
            arready_out <= 1'b0;
            rvalid_out <= 1'b1;
            rdata_out <= read_word;
            rresp_out <= read_ok ? pmd_pkg::RESP_OKAY : pmd_pkg::RESP_SLVERR;
        end else if (rvalid_out) begin
            if (rready_in) begin
                rvalid_out <= 1'b0;
                arready_out <= 1'b1;
            end
        end else begin
            arready_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // per-module controls
    // ------------------------------------------------------------
    always_comb begin
        off_vec.dac = module_disable_ctrl_2[pmd_pkg::DAC_OFF_BIT]; // RQ4
        off_vec.adc = module_disable_ctrl_2[pmd_pkg::ADC_OFF_BIT];
        off_vec.comparator_two = module_disable_ctrl_2[pmd_pkg::COMPARATOR_TWO_OFF_BIT];
        off_vec.comparator_one = module_disable_ctrl_2[pmd_pkg::COMPARATOR_ONE_OFF_BIT];
        // configuration bit set forces the detector off regardless of software
        off_vec.zero_cross_detector = module_disable_ctrl_2[pmd_pkg::ZERO_CROSS_OFF_BIT]
            || zero_cross_config; // RQ5
        off_bits = off_vec;
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            peripheral_sys_clock_en_out <= 1'b1;
        end else begin
            peripheral_sys_clock_en_out <= !module_disable_ctrl_0[pmd_pkg::SYS_CLOCK_GATE_BIT]; // RQ2
        end
    end

    genvar m;
    generate
        for (m = 0; m < pmd_pkg::NUM_MODULES; m++) begin : g_module
            always_ff @(posedge clock_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    module_clock_en_out[m] <= 1'b1;
                    module_reset_out[m] <= 1'b0;
                    module_access_en_out[m] <= 1'b1;
                end else begin
                    // clearing the bit drops reset one edge later; module starts from power-on state
                    module_clock_en_out[m] <= !off_bits[m]
                        && !(uses_sys_clock_in[m] && module_disable_ctrl_0[pmd_pkg::SYS_CLOCK_GATE_BIT]); // RQ3 RQ6
                    module_reset_out[m] <= off_bits[m]; // RQ6 RQ7
                    module_access_en_out[m] <= !off_bits[m]; // RQ6
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence ctrl2_write_s;
        commit && commit_lane && commit_addr == pmd_pkg::MODULE_DISABLE_CTRL_2_OFFSET;
    endsequence

    reset_clears_a: assert property (@(posedge clock_in) $rose(arst_n_in) |-> module_disable_ctrl_2 == 8'h00
        && module_disable_ctrl_0 == 8'h00) else $error("disable bits not clear after reset"); // RQ1
    sys_gate_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        module_disable_ctrl_0[7] |=> !peripheral_sys_clock_en_out) else $error("sys clock not gated"); // RQ2
    other_clock_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        (!uses_sys_clock_in[4] && !off_bits[4]) |=> module_clock_en_out[4])
        else $error("non-consumer lost clock"); // RQ3
    ctrl2_store_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        ctrl2_write_s |=> module_disable_ctrl_2 == ($past(commit_data) & 8'h67))
        else $error("control register 2 write wrong"); // RQ4
    zcd_override_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        zero_cross_config |=> module_reset_out[0]) else $error("config did not disable detector"); // RQ5
    off_holds_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        off_bits[3] |=> (module_reset_out[3] && !module_clock_en_out[3] && !module_access_en_out[3]))
        else $error("disabled adc not held"); // RQ6
    reenable_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        $fell(off_bits[2]) |=> !module_reset_out[2] && module_access_en_out[2])
        else $error("re-enable not released"); // RQ7
    reserved_zero_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        (module_disable_ctrl_2 & 8'h98) == 8'h00 && (module_disable_ctrl_0 & 8'h7f) == 8'h00)
        else $error("unimplemented bit set"); // RQ9
endmodule : peripheral_module_disable

// ===== rtl/pmd_pkg.sv
/*
 * package for the peripheral module disable block: register offsets,
 * field positions, reset values and the bus carrier structs.
 * assumes an axi4-lite master with 32-bit data on the register side.
 */
package pmd_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] MODULE_DISABLE_CTRL_0_OFFSET = 8'h00;
    localparam logic [7:0] MODULE_DISABLE_CTRL_2_OFFSET = 8'h08;
    localparam logic [7:0] MODULE_STATUS_OFFSET = 8'h0c;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SYS_CLOCK_GATE_BIT = 7;
    localparam int DAC_OFF_BIT = 6;
    localparam int ADC_OFF_BIT = 5;
    localparam int COMPARATOR_TWO_OFF_BIT = 2;
    localparam int COMPARATOR_ONE_OFF_BIT = 1;
    localparam int ZERO_CROSS_OFF_BIT = 0;
    localparam logic [7:0] CTRL_0_MASK = 8'h80;
    localparam logic [7:0] CTRL_2_MASK = 8'h67;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int NUM_MODULES = 5;
    // ------------------------------------------------------------
    // axi response codes
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } write_req_s;
    typedef struct packed {
        logic dac;
        logic adc;
        logic comparator_two;
        logic comparator_one;
        logic zero_cross_detector;
    } module_vec_s;
endpackage : pmd_pkg

// ===== tb/peripheral_module_disable_tb_top.sv
/*
 * self-checking bench for peripheral_module_disable: axi4-lite register
 * traffic, per-module disable outputs, system clock gate, config override.
 * assumes the design package and a 50 mhz single clock domain.
 */
`timescale 1ns/10ps
module peripheral_module_disable_tb_top;
    logic clock_in, arst_n_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in, zero_cross_config_in;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, peripheral_sys_clock_en_out;
    logic [7:0] awaddr_in, araddr_in;
    logic [31:0] wdata_in, rdata_out;
    logic [3:0] wstrb_in;
    logic [1:0] bresp_out, rresp_out;
    logic [4:0] uses_sys_clock_in, module_clock_en_out, module_reset_out, module_access_en_out;
    int fails, n_tests;
    localparam logic [7:0] C0 = pmd_pkg::MODULE_DISABLE_CTRL_0_OFFSET;
    localparam logic [7:0] C2 = pmd_pkg::MODULE_DISABLE_CTRL_2_OFFSET;
    localparam logic [7:0] ST = pmd_pkg::MODULE_STATUS_OFFSET;

    peripheral_module_disable dut_u (.clock_in(clock_in), .arst_n_in(arst_n_in), .awvalid_in(awvalid_in),
        .awaddr_in(awaddr_in), .awready_out(awready_out), .wvalid_in(wvalid_in), .wdata_in(wdata_in),
        .wstrb_in(wstrb_in), .wready_out(wready_out), .bvalid_out(bvalid_out), .bresp_out(bresp_out),
        .bready_in(bready_in), .arvalid_in(arvalid_in), .araddr_in(araddr_in), .arready_out(arready_out),
        .rvalid_out(rvalid_out), .rdata_out(rdata_out), .rresp_out(rresp_out), .rready_in(rready_in),
        .zero_cross_config_in(zero_cross_config_in), .uses_sys_clock_in(uses_sys_clock_in),
        .peripheral_sys_clock_en_out(peripheral_sys_clock_en_out), .module_clock_en_out(module_clock_en_out),
        .module_reset_out(module_reset_out), .module_access_en_out(module_access_en_out));

    // ------------------------------------------------------------
    // bus and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic aw_go, w_go;
        @(posedge clock_in);
        awvalid_in <= 1'b1;
        awaddr_in <= a;
        wvalid_in <= 1'b1;
        wdata_in <= d;
        wstrb_in <= s;
        bready_in <= 1'b1;
        #1;
        // halves may be taken on different edges; each released only once taken
        while (awvalid_in || wvalid_in) begin
            aw_go = awvalid_in && awready_out === 1'b1;
            w_go = wvalid_in && wready_out === 1'b1;
            @(posedge clock_in);
            if (aw_go) awvalid_in <= 1'b0;
            if (w_go) wvalid_in <= 1'b0;
            #1;
        end
        while (bvalid_out !== 1'b1) begin
            @(posedge clock_in);
            #1;
        end
        chk("bresp", {30'h0, bresp_out}, {30'h0, er});
        @(posedge clock_in);
        bready_in <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clock_in);
        arvalid_in <= 1'b1;
        araddr_in <= a;
        rready_in <= 1'b1;
        #1;
        while (arready_out !== 1'b1) begin
            @(posedge clock_in);
            #1;
        end
        @(posedge clock_in);
        arvalid_in <= 1'b0;
        #1;
        while (rvalid_out !== 1'b1) begin
            @(posedge clock_in);
            #1;
        end
        chk("rdata", rdata_out, exp);
        chk("rresp", {30'h0, rresp_out}, {30'h0, er});
        @(posedge clock_in);
        rready_in <= 1'b0;
    endtask : axi_rd

    // controls lag the register by one edge and the config input by three; three edges covers both
    task automatic outs(input logic sy, input logic [4:0] ck, input logic [4:0] rs, input logic [4:0] ac);
        repeat (3) @(posedge clock_in);
        #1;
        chk("sys_clock_en", {31'h0, peripheral_sys_clock_en_out}, {31'h0, sy});
        chk("clock_en", {27'h0, module_clock_en_out}, {27'h0, ck});
        chk("reset", {27'h0, module_reset_out}, {27'h0, rs});
        chk("access_en", {27'h0, module_access_en_out}, {27'h0, ac});
    endtask : outs

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_vals;
        outs(1'b1, 5'h1f, 5'h00, 5'h1f);
        axi_rd(C0, 32'h0, pmd_pkg::RESP_OKAY);
        axi_rd(C2, 32'h0, pmd_pkg::RESP_OKAY);
        axi_rd(ST, 32'h0, pmd_pkg::RESP_OKAY);
    endtask : t_reset_vals

    task automatic t_each_bit;
        int pos[5] = '{pmd_pkg::ZERO_CROSS_OFF_BIT, pmd_pkg::COMPARATOR_ONE_OFF_BIT,
            pmd_pkg::COMPARATOR_TWO_OFF_BIT, pmd_pkg::ADC_OFF_BIT, pmd_pkg::DAC_OFF_BIT};
        logic [4:0] v;
        for (int i = 0; i < 5; i++) begin
            v = 5'h01 << i;
            axi_wr(C2, 32'h1 << pos[i], 4'hf, pmd_pkg::RESP_OKAY);
            outs(1'b1, ~v, v, ~v);
            axi_rd(C2, 32'h1 << pos[i], pmd_pkg::RESP_OKAY);
            axi_rd(ST, {27'h0, v}, pmd_pkg::RESP_OKAY);
            axi_wr(C2, 32'h0, 4'hf, pmd_pkg::RESP_OKAY);
            // no further bus traffic until a few cycles after re-enable
            outs(1'b1, 5'h1f, 5'h00, 5'h1f);
        end
    endtask : t_each_bit

    task automatic t_unimpl;
        axi_wr(C2, 32'hffff_ffff, 4'hf, pmd_pkg::RESP_OKAY);
        axi_rd(C2, 32'h67, pmd_pkg::RESP_OKAY);
        outs(1'b1, 5'h00, 5'h1f, 5'h00);
        // low byte strobe off leaves the register alone
        axi_wr(C2, 32'h0, 4'he, pmd_pkg::RESP_OKAY);
        axi_rd(C2, 32'h67, pmd_pkg::RESP_OKAY);
        axi_wr(C0, 32'h7f, 4'hf, pmd_pkg::RESP_OKAY);
        axi_rd(C0, 32'h0, pmd_pkg::RESP_OKAY);
        axi_wr(C2, 32'hffff_ff00, 4'hf, pmd_pkg::RESP_OKAY);
        axi_rd(C2, 32'h0, pmd_pkg::RESP_OKAY);
        outs(1'b1, 5'h1f, 5'h00, 5'h1f);
    endtask : t_unimpl

    task automatic t_sys_clock;
        uses_sys_clock_in <= 5'h05;
        axi_wr(C0, 32'hff, 4'hf, pmd_pkg::RESP_OKAY);
        axi_rd(C0, 32'h80, pmd_pkg::RESP_OKAY);
        outs(1'b0, 5'h1a, 5'h00, 5'h1f);
        axi_wr(C0, 32'h0, 4'hf, pmd_pkg::RESP_OKAY);
        outs(1'b1, 5'h1f, 5'h00, 5'h1f);
        uses_sys_clock_in <= 5'h1f;
    endtask : t_sys_clock

    task automatic t_config;
        zero_cross_config_in <= 1'b1;
        outs(1'b1, 5'h1e, 5'h01, 5'h1e);
        axi_rd(ST, 32'h01, pmd_pkg::RESP_OKAY);
        axi_rd(C2, 32'h0, pmd_pkg::RESP_OKAY);
        zero_cross_config_in <= 1'b0;
        outs(1'b1, 5'h1f, 5'h00, 5'h1f);
    endtask : t_config

    task automatic t_errors;
        axi_wr(8'h04, 32'hff, 4'hf, pmd_pkg::RESP_SLVERR);
        axi_rd(8'h04, 32'h0, pmd_pkg::RESP_SLVERR);
        axi_wr(ST, 32'hff, 4'hf, pmd_pkg::RESP_OKAY);
        axi_rd(ST, 32'h0, pmd_pkg::RESP_OKAY);
    endtask : t_errors

    task automatic t_mid_reset;
        axi_wr(C2, 32'h67, 4'hf, pmd_pkg::RESP_OKAY);
        axi_wr(C0, 32'h80, 4'hf, pmd_pkg::RESP_OKAY);
        outs(1'b0, 5'h00, 5'h1f, 5'h00);
        arst_n_in <= 1'b0;
        outs(1'b1, 5'h1f, 5'h00, 5'h1f);
        arst_n_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        axi_rd(C2, 32'h0, pmd_pkg::RESP_OKAY);
        axi_rd(C0, 32'h0, pmd_pkg::RESP_OKAY);
    endtask : t_mid_reset

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic end_sim;
        if (fails == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end

    initial begin
        repeat (20000) @(posedge clock_in);
        fails++;
        end_sim();
    end

    initial begin
        fails = 0;
        n_tests = 0;
        arst_n_in = 1'b0;
        {awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in, zero_cross_config_in} = 6'h00;
        awaddr_in = 8'h00;
        araddr_in = 8'h00;
        wdata_in = 32'h0;
        wstrb_in = 4'h0;
        uses_sys_clock_in = 5'h1f;
        repeat (4) @(posedge clock_in);
        arst_n_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        t_reset_vals();
        t_each_bit();
        t_unimpl();
        t_sys_clock();
        t_config();
        t_errors();
        t_mid_reset();
        end_sim();
    end
endmodule : peripheral_module_disable_tb_top
